// ---- design/nand_spi_pkg.sv ----
/*
  Constants, types and the opcode decoder of the serial NAND front end.
  Assumes one clock domain for all users; the SPI pins are synchronised
  by the front end itself.
*/
// Contract
// RL1 - Columns 000h-7FFh are main area in four parts, 800h-83Fh spare in four.
// RL2 - Single line: capture input on sclk rise, drive output on sclk fall.
// RL3 - Both clock modes 0 and 3 work; idle clock level is the master's choice.
// RL4 - Four-line commands use all four lines; quad enable bit must be set.
// RL5 - Four-line load/read: opcode and address single line, data four lines.
// RL6 - Pause freezes only serial traffic, never a running internal cycle.
// RL7 - Pause starts at pause fall if sclk low, else when sclk next goes low.
// RL8 - Pause ends at pause rise if sclk low, else when sclk next goes low.
// RL9 - While paused, outputs float, clock and input ignored, state kept.
// RL10 - Chip select rising while paused resets the interface logic.
// RL11 - All opcode, address and data bytes travel most significant bit first.
// RL12 - First rise after select is opcode bit one; full opcode comes first.
// RL13 - Array commands are ignored while an internal cycle is busy.
// RL14 - Erase, execute, page read take 3 address bytes; 04h/06h/FFh take none.
// RL15 - Feature read and write take one address byte and exactly one data byte.
// RL16 - Identification read needs address 00h and returns two bytes.
// RL17 - Buffer reads take two column bytes, one dummy, then 1 to 2112 bytes.
// RL18 - Quad enable bit low: guard and pause pins; high: extra data lines.
// RL19 - Status feature C0h bit 0 reads 1 while an internal cycle runs.
// RL20 - Chip select rise ends framing; unknown opcodes ignored until then.
// RL21 - Program loads take two column bytes then 1 to 2112 data bytes.
package nand_spi_pkg;
   localparam logic [7:0] OP_ERASE  = 8'hd8;
   localparam logic [7:0] OP_PEXEC  = 8'h10;
   localparam logic [7:0] OP_PREAD  = 8'h13;
   localparam logic [7:0] OP_WRDI   = 8'h04;
   localparam logic [7:0] OP_WREN   = 8'h06;
   localparam logic [7:0] OP_RESET  = 8'hff;
   localparam logic [7:0] OP_GETF   = 8'h0f;
   localparam logic [7:0] OP_SETF   = 8'h1f;
   localparam logic [7:0] OP_LOAD   = 8'h02;
   localparam logic [7:0] OP_LOAD4  = 8'h32;
   localparam logic [7:0] OP_LOADR  = 8'h84;
   localparam logic [7:0] OP_LOADR4 = 8'h34;
   localparam logic [7:0] OP_RD     = 8'h03;
   localparam logic [7:0] OP_RDF    = 8'h0b;
   localparam logic [7:0] OP_RD4    = 8'h6b;
   localparam logic [7:0] OP_ID     = 8'h9f;
   localparam logic [7:0] ID_ADDR     = 8'h00;
   localparam logic [7:0] FEAT_STATUS = 8'hc0;
   localparam int         BUSY_BIT    = 0;
   localparam logic [15:0] MAIN_LAST  = 16'h07ff;
   localparam logic [15:0] SPARE_LAST = 16'h083f;
   localparam int MAIN_PART_LSB  = 9;
   localparam int SPARE_PART_LSB = 4;
   localparam logic [11:0] LIM_PAGE = 12'h840;
   localparam logic [11:0] LIM_FEAT = 12'h001;
   localparam logic [11:0] LIM_ID   = 12'h002;
   localparam logic [11:0] LIM_NONE = 12'h000;
   localparam logic [1:0]  HDR_ZERO  = 2'h0;
   localparam logic [1:0]  HDR_ONE   = 2'h1;
   localparam logic [1:0]  HDR_TWO   = 2'h2;
   localparam logic [1:0]  HDR_THREE = 2'h3;
   localparam logic [2:0]  BYTE_LAST = 3'h7;
   localparam logic [2:0]  NIB_LAST  = 3'h4;
   localparam logic [2:0]  NIB_STEP  = 3'h4;
   localparam int          FIFO_W = 8;
   localparam int          FIFO_D = 8;

   typedef enum logic [2:0] {
      ST_OPCODE = 3'h0,
      ST_HDR    = 3'h1,
      ST_DIN    = 3'h3,
      ST_DOUT   = 3'h5,
      ST_IGNORE = 3'h6
   } phase_type;

   typedef enum logic [1:0] {
      DK_NONE = 2'h0,
      DK_IN   = 2'h1,
      DK_OUT  = 2'h2
   } dkind_type;

   typedef struct packed {
      logic        known;
      logic        array;
      logic        quad;
      logic [1:0]  hdr;
      dkind_type   kind;
      logic [11:0] limit;
   } decode_type;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [23:0] addr;
   } cmd_type;

   typedef struct packed {
      logic [15:0] col;
      logic        valid;
      logic        spare;
      logic [1:0]  part;
   } column_type;

   function automatic decode_type decode(input logic [7:0] op);
      decode_type d;
      d = '{known: 1'b1, array: 1'b1, quad: 1'b0, hdr: HDR_ZERO,
            kind: DK_NONE, limit: LIM_NONE};
      case (op)
         OP_ERASE, OP_PEXEC, OP_PREAD: d.hdr = HDR_THREE; // RL14
         OP_WRDI, OP_WREN, OP_RESET: d.array = 1'b0; // RL14
         OP_GETF: begin // RL15
            d = '{1'b1, 1'b0, 1'b0, HDR_ONE, DK_OUT, LIM_FEAT};
         end
         OP_SETF: begin // RL15
            d = '{1'b1, 1'b0, 1'b0, HDR_ONE, DK_IN, LIM_FEAT};
         end
         OP_ID: begin // RL16
            d = '{1'b1, 1'b0, 1'b0, HDR_ONE, DK_OUT, LIM_ID};
         end
         OP_LOAD, OP_LOADR: begin // RL21
            d = '{1'b1, 1'b1, 1'b0, HDR_TWO, DK_IN, LIM_PAGE};
         end
         OP_LOAD4, OP_LOADR4: begin // RL5
            d = '{1'b1, 1'b1, 1'b1, HDR_TWO, DK_IN, LIM_PAGE};
         end
         OP_RD, OP_RDF: begin // RL17
            d = '{1'b1, 1'b1, 1'b0, HDR_THREE, DK_OUT, LIM_PAGE};
         end
         OP_RD4: begin // RL5
            d = '{1'b1, 1'b1, 1'b1, HDR_THREE, DK_OUT, LIM_PAGE};
         end
         default: d.known = 1'b0; // RL20
      endcase
      return d;
   endfunction
endpackage

// ---- design/serial_nand_spi_front_end.sv ----
/*
  Serial NAND SPI front end: pin synchroniser, command framing, pause
  handling, column decode, write-data FIFO and read-data serialiser.
  Assumes sclk is slow against clock_i (at least four cycles per half
  period) and that the core answers each read request within that time.
*/
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         clock_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = D[AW:0];
   localparam logic [AW:0] EMPTY = '0;

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } fifo_state_type;

   fifo_state_type q, n;
   logic push, pop;

   // Depth must be a power of two so pointers wrap on their own
   always_comb begin
      n = q;
      in_ready_o = q.cnt != FULL;
      out_valid_o = q.cnt != EMPTY;
      out_data_o = q.mem[q.rp];
      push = in_valid_i & in_ready_o;
      pop = out_valid_o & out_ready_i;
      if (push) begin
         n.mem[q.wp] = in_data_i;
         n.wp = q.wp + 1'b1;
      end
      if (pop) begin
         n.rp = q.rp + 1'b1;
      end
      n.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
endmodule

module serial_nand_spi_front_end
   import nand_spi_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic [3:0]  quad_line_i,
   output logic [3:0]       quad_line_o,
   output logic [3:0]       quad_line_oe_o,
   input  wire logic        quad_enable_bit_i,
   input  wire logic        busy_i,
   output logic             busy_flag_o,
   output logic             write_guard_n_o,
   output logic             paused_o,
   output cmd_type          cmd_o,
   output logic             cmd_valid_o,
   output column_type       column_o,
   output logic             frame_end_o,
   output logic [7:0]       wr_data_o,
   output logic             wr_valid_o,
   input  wire logic        wr_ready_i,
   output logic             overrun_o,
   output logic             rd_req_o,
   input  wire logic [7:0]  rd_data_i,
   input  wire logic        rd_valid_i
);
   typedef struct packed {
      logic [5:0]  s1;
      logic [5:0]  s2;
      logic        sclk_d;
      logic        sel;
      logic        paused;
      phase_type   st;
      decode_type  dec;
      logic [2:0]  bitc;
      logic [1:0]  hleft;
      logic [7:0]  sh;
      logic [11:0] dcnt;
      logic [7:0]  obyte;
      logic [2:0]  ocnt;
      logic [7:0]  nbyte;
      logic        nvalid;
      logic [3:0]  out;
      logic [3:0]  oe;
      logic [3:0]  eo;
      logic [7:0]  hbyte;
      logic        hvalid;
      logic [7:0]  wd;
      logic        wv;
      logic        ovr;
      logic        rd_req;
      logic        busy;
      logic        wg_n;
      cmd_type     cmd;
      logic        cmd_valid;
      column_type  col;
      logic        fend;
   } fe_state_type;

   fe_state_type q, n;
   logic        f_in_ready;
   logic        f_out_valid;
   logic [7:0]  f_out_data;
   logic        f_out_ready;

   byte_fifo #(.W(FIFO_W), .D(FIFO_D)) u_wr_fifo (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .in_valid_i  (q.hvalid),
      .in_data_i   (q.hbyte),
      .in_ready_o  (f_in_ready),
      .out_valid_o (f_out_valid),
      .out_data_o  (f_out_data),
      .out_ready_i (f_out_ready)
   );

   always_comb begin
      logic        sclk, csn, rise, fall, want, qd, lastb, ok;
      logic [3:0]  l;
      logic [7:0]  b;
      logic [23:0] a;
      logic [15:0] c;
      decode_type  d;
      sclk = 1'b0;
      csn = 1'b1;
      rise = 1'b0;
      fall = 1'b0;
      want = 1'b0;
      qd = 1'b0;
      lastb = 1'b0;
      ok = 1'b0;
      l = '0;
      b = '0;
      a = '0;
      c = '0;
      d = '0;
      n = q;
      n.s1 = {quad_line_i, cs_n_i, sclk_i};
      n.s2 = q.s1;
      sclk = q.s2[0];
      csn = q.s2[1];
      l = q.s2[5:2];
      n.sclk_d = sclk;
      n.sel = ~csn;
      n.fend = csn & q.sel;
      n.cmd_valid = 1'b0;
      n.rd_req = 1'b0;
      n.busy = busy_i; // RL6
      n.wg_n = quad_enable_bit_i | l[2]; // RL18
      want = ~quad_enable_bit_i & ~l[3]; // RL18
      qd = q.dec.quad;
      // Edges seen while paused are dropped so counts stay frozen
      rise = sclk & ~q.sclk_d & ~q.paused; // RL9
      fall = ~sclk & q.sclk_d & ~q.paused; // RL9
      // Pause follows the pin only while sclk is low
      if (csn) begin
         n.paused = 1'b0;
      end else if (~sclk) begin
         n.paused = want; // RL7 RL8
      end

      // Staged write byte leaves as soon as the FIFO takes it
      if (q.hvalid & f_in_ready) begin
         n.hvalid = 1'b0;
      end
      f_out_ready = ~q.wv | wr_ready_i;
      if (f_out_valid & f_out_ready) begin
         n.wd = f_out_data;
         n.wv = 1'b1;
      end else if (wr_ready_i) begin
         n.wv = 1'b0;
      end

      if (q.st == ST_DOUT & rd_valid_i & ~q.nvalid) begin
         n.nbyte = rd_data_i;
         if (q.cmd.opcode == OP_GETF & q.cmd.addr[7:0] == FEAT_STATUS) begin
            n.nbyte[BUSY_BIT] = busy_i; // RL19
         end
         n.nvalid = 1'b1;
      end

      if (csn) begin
         n.st = ST_OPCODE; // RL10 RL20
         n.bitc = '0;
         n.oe = '0;
         n.ocnt = '0;
         n.dcnt = '0;
         n.nvalid = 1'b0;
      end else if (rise) begin // RL2 RL3
         case (q.st)
            ST_OPCODE: begin
               b = {q.sh[6:0], l[0]}; // RL11 RL12
               n.sh = b;
               n.bitc = q.bitc + 1'b1;
               if (q.bitc == BYTE_LAST) begin
                  d = decode(b);
                  n.dec = d;
                  n.cmd.opcode = b;
                  n.cmd.addr = '0;
                  ok = d.known & ~(d.array & busy_i) // RL13
                     & ~(d.quad & ~quad_enable_bit_i); // RL4
                  if (~ok) begin
                     n.st = ST_IGNORE; // RL20
                  end else if (d.hdr == HDR_ZERO) begin
                     n.cmd_valid = 1'b1; // RL14
                     n.st = ST_IGNORE;
                  end else begin
                     n.hleft = d.hdr;
                     n.st = ST_HDR;
                  end
               end
            end
            ST_HDR: begin
               a = {q.cmd.addr[22:0], l[0]}; // RL5 RL11
               n.cmd.addr = a;
               n.bitc = q.bitc + 1'b1;
               if (q.bitc == BYTE_LAST) begin
                  n.hleft = q.hleft - 1'b1;
                  if (q.hleft == HDR_ONE) begin
                     c = (q.dec.kind == DK_OUT & q.dec.hdr == HDR_THREE)
                        ? a[23:8] : a[15:0];
                     n.col.col = c; // RL1
                     n.col.valid = c <= SPARE_LAST;
                     n.col.spare = c > MAIN_LAST;
                     n.col.part = (c > MAIN_LAST) ? c[SPARE_PART_LSB +: 2]
                        : c[MAIN_PART_LSB +: 2];
                     n.dcnt = '0;
                     if (q.cmd.opcode == OP_ID & a[7:0] != ID_ADDR) begin
                        n.st = ST_IGNORE; // RL16
                     end else begin
                        n.cmd_valid = 1'b1;
                        case (q.dec.kind)
                           DK_IN: n.st = ST_DIN;
                           DK_OUT: begin
                              n.st = ST_DOUT;
                              n.rd_req = 1'b1;
                              n.nvalid = 1'b0;
                           end
                           default: n.st = ST_IGNORE;
                        endcase
                     end
                  end
               end
            end
            ST_DIN: begin
               if (qd) begin
                  b = {q.sh[3:0], l}; // RL4 RL5
                  n.bitc = q.bitc + NIB_STEP;
                  lastb = q.bitc == NIB_LAST;
               end else begin
                  b = {q.sh[6:0], l[0]}; // RL11
                  n.bitc = q.bitc + 1'b1;
                  lastb = q.bitc == BYTE_LAST;
               end
               n.sh = b;
               if (lastb & q.dcnt < q.dec.limit) begin // RL15 RL21
                  n.dcnt = q.dcnt + 1'b1;
                  n.hbyte = b;
                  n.hvalid = 1'b1;
                  // A byte still waiting for FIFO room is overwritten
                  if (q.hvalid & ~f_in_ready) begin
                     n.ovr = 1'b1;
                  end
               end
            end
            default: begin
            end
         endcase
      end else if (fall & q.st == ST_DOUT) begin // RL2
         if (q.ocnt == '0) begin
            if (q.dcnt < q.dec.limit & q.nvalid) begin // RL15 RL16 RL17
               b = q.nbyte;
               n.nvalid = 1'b0;
               n.dcnt = q.dcnt + 1'b1;
               n.rd_req = q.dcnt + 1'b1 < q.dec.limit;
               if (qd) begin
                  n.out = b[7:4]; // RL4 RL5
                  n.oe = 4'hf;
                  n.obyte = {b[3:0], 4'h0};
                  n.ocnt = 3'h1;
               end else begin
                  n.out = {2'h0, b[7], 1'b0}; // RL11
                  n.oe = 4'h2;
                  n.obyte = {b[6:0], 1'b0};
                  n.ocnt = BYTE_LAST;
               end
            end else begin
               // Past the limit or starved: let the lines float
               n.oe = '0;
            end
         end else begin
            n.ocnt = q.ocnt - 1'b1;
            if (qd) begin
               n.out = q.obyte[7:4];
               n.obyte = {q.obyte[3:0], 4'h0};
            end else begin
               n.out = {2'h0, q.obyte[7], 1'b0};
               n.obyte = {q.obyte[6:0], 1'b0};
            end
         end
      end
      n.eo = n.paused ? 4'h0 : n.oe; // RL9
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
         q.s1 <= '1;
         q.s2 <= '1;
      end else begin
         q <= n;
      end
   end

   assign quad_line_o = q.out;
   assign quad_line_oe_o = q.eo;
   assign busy_flag_o = q.busy;
   assign write_guard_n_o = q.wg_n;
   assign paused_o = q.paused;
   assign cmd_o = q.cmd;
   assign cmd_valid_o = q.cmd_valid;
   assign column_o = q.col;
   assign frame_end_o = q.fend;
   assign wr_data_o = q.wd;
   assign wr_valid_o = q.wv;
   assign overrun_o = q.ovr;
   assign rd_req_o = q.rd_req;
endmodule

`default_nettype wire

// ---- test/nand_spi_monitor.sv ----
/*
  Checker of the serial NAND front end, bound to its top module.
  Assumes one clock domain with asynchronous reset rst_i.
*/
`timescale 1ns/1ps
`default_nettype none
module nand_spi_monitor (
   input wire logic       clock_i,
   input wire logic       rst_i,
   input wire logic       cs_n_i,
   input wire logic [3:0] quad_line_oe_o,
   input wire logic       quad_enable_bit_i,
   input wire logic       busy_i,
   input wire logic       busy_flag_o,
   input wire logic       write_guard_n_o,
   input wire logic       paused_o,
   input wire logic       cmd_valid_o,
   input wire logic       frame_end_o,
   input wire logic [7:0] wr_data_o,
   input wire logic       wr_valid_o,
   input wire logic       wr_ready_i,
   input wire logic       overrun_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   AST_PAUSE_FLOAT: assert property (
      paused_o ##1 paused_o |-> quad_line_oe_o == 4'h0) else $error("drive in pause");
   AST_DESEL_FLOAT: assert property (
      cs_n_i [*5] |-> quad_line_oe_o == 4'h0) else $error("drive while idle");
   AST_DESEL_NOPAUSE: assert property (
      cs_n_i [*5] |-> !paused_o) else $error("pause while deselected");
   AST_FRAME_END: assert property (
      $rose(cs_n_i) |-> ##[1:5] frame_end_o) else $error("no frame end");
   AST_CMD_PULSE: assert property (
      cmd_valid_o |=> !cmd_valid_o) else $error("command pulse too long");
   AST_OE_SHAPE: assert property (
      quad_line_oe_o inside {4'h0, 4'h2, 4'hf}) else $error("bad enable pattern");
   AST_QUAD_QE: assert property (
      quad_line_oe_o == 4'hf |-> quad_enable_bit_i) else $error("quad without enable");
   AST_GUARD_QE: assert property (
      quad_enable_bit_i |=> write_guard_n_o) else $error("guard active in quad");
   AST_WR_HOLD: assert property (
      wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o))
      else $error("write byte dropped under stall");
   AST_OVERRUN_STICKY: assert property (
      overrun_o |=> overrun_o) else $error("overrun cleared");
   AST_BUSY_FLAG: assert property (
      busy_i [*2] |-> busy_flag_o) else $error("busy flag missing");
endmodule
`default_nettype wire

// ---- test/spi_host_model.sv ----
/*
  Host SPI master model: frames, byte or nibble shifts, raw pin moves.
  Assumes a 4 ns clock_i; every pin change lands on its falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input  wire logic       clock_i,
   input  wire logic [3:0] line_i,
   output logic            sclk_o,
   output logic            cs_n_o,
   output logic [3:0]      line_o,
   output logic [3:0]      line_oe_o
);
   // Twenty cycles of 4 ns give each 80 ns half of the 160 ns serial clock
   localparam int HALF = 20;
   logic idle_high;
   initial begin
      sclk_o    = 1'b0;
      cs_n_o    = 1'b1;
      line_o    = 4'hf;
      line_oe_o = 4'hd;
      idle_high = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic frame_start(input logic mode3);
      idle_high = mode3;
      sclk_o    = mode3;
      wait_clk(HALF);
      cs_n_o = 1'b0;
      wait_clk(HALF);
   endtask
   task automatic frame_end();
      wait_clk(HALF);
      sclk_o = idle_high;
      wait_clk(HALF);
      cs_n_o    = 1'b1;
      line_o    = 4'hf;
      line_oe_o = 4'hd;
      wait_clk(2 * HALF);
   endtask
   // Released lines read high through the board pull-ups
   task automatic shift(input logic [7:0] tx, input logic quad,
                        input logic drive, output logic [7:0] rx);
      rx = 8'h00;
      for (int n = 0; n < (quad ? 2 : 8); n++) begin
         sclk_o = 1'b0;
         if (quad) begin
            line_oe_o = drive ? 4'hf : 4'h0;
            line_o    = tx[7-4*n -: 4];
         end else begin
            line_oe_o = 4'hd;
            line_o[0] = tx[7-n];
         end
         wait_clk(HALF);
         sclk_o = 1'b1;
         rx     = quad ? {rx[3:0], line_i} : {rx[6:0], line_i[1]};
         wait_clk(HALF);
      end
   endtask
   task automatic set_pins(input logic s, input logic [1:0] hi, input int n);
      sclk_o      = s;
      line_o[3:2] = hi;
      wait_clk(n);
   endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
/*
  Bench of the serial NAND front end: host model, core read answers and
  write sink. Assumes pull-ups on all four lines.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import nand_spi_pkg::*;
   logic       clock_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       qe = 1'b0, busy = 1'b0, wr_ready = 1'b1;
   logic       sclk, cs_n, rd_req, cmd_valid, wr_valid, overrun;
   logic       busy_flag, guard_n, paused, frame_end;
   logic [3:0] h_out, h_oe, d_out, oe, pin;
   logic [7:0] wr_data, rd_data = 8'h00, rd_src [4];
   logic       rd_valid = 1'b0;
   logic [1:0] rd_idx = 2'h0;
   cmd_type    cmd;
   column_type col;
   int         n_cmd = 0, miscompares = 0, check_count = 0;
   logic [7:0] wr_q [$];
   always #2 clock_i = ~clock_i;
   assign pin = (h_oe & h_out) | (~h_oe & oe & d_out) | (~h_oe & ~oe);
   serial_nand_spi_front_end serial_nand_spi_front_end_inst (
      .clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .quad_line_i(pin), .quad_line_o(d_out), .quad_line_oe_o(oe),
      .quad_enable_bit_i(qe), .busy_i(busy), .busy_flag_o(busy_flag),
      .write_guard_n_o(guard_n), .paused_o(paused), .cmd_o(cmd),
      .cmd_valid_o(cmd_valid), .column_o(col), .frame_end_o(frame_end),
      .wr_data_o(wr_data), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
      .overrun_o(overrun), .rd_req_o(rd_req), .rd_data_i(rd_data),
      .rd_valid_i(rd_valid));
   spi_host_model spi_host_model_inst (
      .clock_i(clock_i), .line_i(pin), .sclk_o(sclk), .cs_n_o(cs_n),
      .line_o(h_out), .line_oe_o(h_oe));
   always @(posedge clock_i) begin
      if (cmd_valid) n_cmd++;
      if (wr_valid && wr_ready) wr_q.push_back(wr_data);
   end
   always @(negedge clock_i) begin
      rd_valid <= rd_req;
      if (rd_req) begin
         rd_data <= rd_src[rd_idx];
         rd_idx  <= rd_idx + 2'h1;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t %s: %h not %h", $time, what, seen, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] b, input logic q, output logic [7:0] r);
      spi_host_model_inst.shift(b, q, 1'b1, r);
   endtask
   task automatic fin();
      spi_host_model_inst.frame_end();
   endtask
   task automatic head(input logic m3, input logic [7:0] op,
                       input logic [23:0] a, input int n);
      logic [7:0] r;
      spi_host_model_inst.frame_start(m3);
      xfer(op, 1'b0, r);
      for (int k = n - 1; k >= 0; k--) xfer(a[8*k +: 8], 1'b0, r);
   endtask
   task automatic t_feature(input logic m3, input logic b);
      int n0;
      logic [7:0] r, r2;
      n0 = n_cmd;
      rd_idx = 2'h0;
      rd_src[0] = 8'h5a;
      busy = b;
      head(m3, OP_GETF, 24'h0000c0, 1);
      xfer(8'h00, 1'b0, r);
      xfer(8'h00, 1'b0, r2);
      fin();
      check(n_cmd - n0, 1, "feature count");
      check(cmd, {OP_GETF, 24'h0000c0}, "feature command");
      check({r, r2}, {7'h2d, b, 8'hff}, "status bytes");
      check(busy_flag, b, "busy flag");
      busy = 1'b0;
   endtask
   task automatic t_id();
      int n0;
      logic [7:0] r [3];
      rd_idx = 2'h0;
      rd_src = '{8'h3c, 8'h71, 8'h00, 8'h00}; // Arbitrary identity bytes
      head(1'b0, OP_ID, 24'h0, 1);
      for (int k = 0; k < 3; k++) xfer(8'h00, 1'b0, r[k]);
      fin();
      check({r[0], r[1], r[2]}, 24'h3c71ff, "id bytes");
      n0 = n_cmd;
      head(1'b0, OP_ID, 24'h000001, 1);
      xfer(8'h00, 1'b0, r[0]);
      fin();
      check({8'(n_cmd - n0), r[0]}, 16'h00ff, "id bad address");
   endtask
   task automatic t_decode();
      int n0;
      logic [7:0] ops [8] = '{OP_ERASE, OP_PEXEC, OP_PREAD, 8'h55, OP_WRDI,
                              OP_WREN, OP_RESET, OP_ERASE};
      for (int i = 0; i < 8; i++) begin
         busy = (i == 7);
         n0 = n_cmd;
         head(1'b0, ops[i], 24'h01a2b3, (i < 4 || i == 7) ? 3 : 0);
         fin();
         check(n_cmd - n0, i != 3 && i != 7, "decode count");
         if (i != 3 && i != 7) check(cmd[31:24], ops[i], "opcode");
         if (i < 3) check(cmd, {ops[i], 24'h01a2b3}, "address");
      end
      busy = 1'b0;
   endtask
   task automatic t_load();
      int n0;
      logic [7:0] r;
      wr_q.delete();
      qe = 1'b1;
      head(1'b0, OP_LOAD4, 24'h000400, 2);
      for (int k = 0; k < 3; k++) xfer(8'h96 + 8'(k), 1'b1, r);
      fin();
      check(col, {16'h0400, 4'b1010}, "main column");
      check({wr_q[0], wr_q[1], wr_q[2]}, 24'h969798, "quad load");
      qe = 1'b0;
      n0 = n_cmd;
      head(1'b0, OP_LOADR4, 24'h000010, 2);
      fin();
      check(n_cmd - n0, 0, "quad without enable");
      head(1'b0, OP_LOADR, 24'h000840, 2);
      fin();
      check(col.valid, 1'b0, "column past spare");
      wr_ready = 1'b0;
      wr_q.delete();
      head(1'b0, OP_LOAD, 24'h000835, 2);
      for (int k = 0; k < 12; k++) xfer(8'h40 + 8'(k), 1'b0, r);
      fin();
      check({col, overrun}, {16'h0835, 5'b11111}, "spare column");
      wr_ready = 1'b1;
      spi_host_model_inst.wait_clk(40);
      check(wr_q.size() >= 8, 1, "drained bytes");
      for (int k = 0; k < 8; k++) check(wr_q[k], 8'h40 + k, "load byte");
   endtask
   task automatic t_qread();
      logic [7:0] r0, r1;
      qe = 1'b1;
      rd_idx = 2'h0;
      rd_src = '{8'ha5, 8'h3c, 8'h00, 8'h00};
      head(1'b0, OP_RD4, 24'h001000, 3);
      spi_host_model_inst.shift(8'h00, 1'b1, 1'b0, r0);
      spi_host_model_inst.shift(8'h00, 1'b1, 1'b0, r1);
      fin();
      check(cmd, {OP_RD4, 24'h001000}, "quad read command");
      check({r0, r1}, 16'ha53c, "quad read data");
      qe = 1'b0;
      spi_host_model_inst.set_pins(1'b0, 2'b10, 8);
      check(guard_n, 1'b0, "guard pin");
      qe = 1'b1;
      spi_host_model_inst.set_pins(1'b0, 2'b10, 4);
      check(guard_n, 1'b1, "guard in quad");
      spi_host_model_inst.set_pins(1'b0, 2'b11, 4);
      qe = 1'b0;
   endtask
   task automatic t_pause();
      logic [7:0] r;
      rd_idx = 2'h0;
      rd_src[0] = 8'hc3;
      busy = 1'b1;
      head(1'b0, OP_GETF, 24'h0, 0);
      spi_host_model_inst.set_pins(1'b1, 2'b01, 10);
      check(paused, 1'b0, "pause with clock high");
      spi_host_model_inst.set_pins(1'b0, 2'b01, 8);
      check({paused, oe}, 5'h10, "pause entry");
      spi_host_model_inst.set_pins(1'b1, 2'b01, 8);
      spi_host_model_inst.set_pins(1'b0, 2'b01, 8);
      spi_host_model_inst.set_pins(1'b0, 2'b11, 8);
      check({paused, busy_flag}, 2'b01, "pause exit");
      xfer(8'hc0, 1'b0, r);
      xfer(8'h00, 1'b0, r);
      fin();
      check(r, 8'hc3, "status after pause");
      busy = 1'b0;
      head(1'b0, OP_GETF, 24'h0, 0);
      spi_host_model_inst.set_pins(1'b0, 2'b01, 8);
      spi_host_model_inst.cs_n_o = 1'b1;
      spi_host_model_inst.wait_clk(8);
      check(paused, 1'b0, "deselect in pause");
      fin();
   endtask
   task automatic tally_and_finish();
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clock_i);
      t_pause();
      t_feature(1'b0, 1'b0);
      t_feature(1'b1, 1'b1);
      t_id();
      t_decode();
      t_qread();
      t_load();
      tally_and_finish();
   end
   initial begin
      repeat (90000) @(posedge clock_i);
      miscompares++;
      tally_and_finish();
   end
endmodule
bind serial_nand_spi_front_end nand_spi_monitor nand_spi_monitor_inst (
   .clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
   .quad_line_oe_o(quad_line_oe_o), .quad_enable_bit_i(quad_enable_bit_i),
   .busy_i(busy_i), .busy_flag_o(busy_flag_o),
   .write_guard_n_o(write_guard_n_o), .paused_o(paused_o),
   .cmd_valid_o(cmd_valid_o), .frame_end_o(frame_end_o),
   .wr_data_o(wr_data_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
   .overrun_o(overrun_o));
`default_nettype wire
